// ### inc/gpt_pkg.sv
// Package with register map, field positions, pad types and reset values of the port block
package gpt_pkg;

   // Register indices; byte address is four times the index
   localparam logic [9:0] GPT_IDX_P1_FSEL = 10'h0d5;
   localparam logic [9:0] GPT_IDX_P3_FSEL = 10'h0d7;
   localparam logic [9:0] GPT_IDX_P1_LATCH = 10'h0d9;
   localparam logic [9:0] GPT_IDX_P2_LATCH = 10'h0da;
   localparam logic [9:0] GPT_IDX_P3_LATCH = 10'h0db;
   localparam logic [9:0] GPT_IDX_PORT1_DIRECTION = 10'h244;
   localparam logic [9:0] GPT_IDX_PORT1_PAD_CONFIG = 10'h245;
   localparam logic [9:0] GPT_IDX_PORT2_DIRECTION = 10'h248;
   localparam logic [9:0] GPT_IDX_PORT2_PAD_CONFIG = 10'h249;
   localparam logic [9:0] GPT_IDX_PORT3_DIRECTION = 10'h24c;

   // Byte addresses on the register bus
   localparam logic [11:0] GPT_ADDR_P1_FSEL = {GPT_IDX_P1_FSEL, 2'h0};
   localparam logic [11:0] GPT_ADDR_P3_FSEL = {GPT_IDX_P3_FSEL, 2'h0};
   localparam logic [11:0] GPT_ADDR_P1_LATCH = {GPT_IDX_P1_LATCH, 2'h0};
   localparam logic [11:0] GPT_ADDR_P2_LATCH = {GPT_IDX_P2_LATCH, 2'h0};
   localparam logic [11:0] GPT_ADDR_P3_LATCH = {GPT_IDX_P3_LATCH, 2'h0};
   localparam logic [11:0] GPT_ADDR_PORT1_DIRECTION = {GPT_IDX_PORT1_DIRECTION, 2'h0};
   localparam logic [11:0] GPT_ADDR_PORT1_PAD_CONFIG = {GPT_IDX_PORT1_PAD_CONFIG, 2'h0};
   localparam logic [11:0] GPT_ADDR_PORT2_DIRECTION = {GPT_IDX_PORT2_DIRECTION, 2'h0};
   localparam logic [11:0] GPT_ADDR_PORT2_PAD_CONFIG = {GPT_IDX_PORT2_PAD_CONFIG, 2'h0};
   localparam logic [11:0] GPT_ADDR_PORT3_DIRECTION = {GPT_IDX_PORT3_DIRECTION, 2'h0};

   // Port-one pad configuration fields
   localparam int GPT_P1CFG_PU = 0;
   localparam int GPT_P1CFG_NMOS = 1;
   localparam int GPT_P1CFG_WEAK = 2;
   localparam int GPT_P1CFG_KS = 3;
   // Port-two pad configuration fields (per pin: base plus pin number)
   localparam int GPT_P2CFG_PU = 0;
   localparam int GPT_P2CFG_NMOS = 2;

   // Bus responses
   localparam logic [1:0] GPT_RESP_OKAY = 2'h0;
   localparam logic [1:0] GPT_RESP_SLVERR = 2'h2;

   // Key-strobe pull-up window
   localparam int GPT_CLK_PERIOD_NS = 50;
   localparam int GPT_KS_WINDOW_NS = 30000;
   localparam logic [15:0] GPT_KS_CYCLES = 16'(GPT_KS_WINDOW_NS / GPT_CLK_PERIOD_NS);

   // Pad inputs sampled as synchronous levels
   typedef struct packed {
      logic [1:0] p1_in;
      logic [1:0] p2_in;
      logic [7:0] p3_in;
   } gpt_pads_in_t;

   // Side band from the LCD controller
   typedef struct packed {
      logic enable;
      logic backplane_low;
      logic [15:0] remain;
      logic [7:0] column_drive;
   } gpt_lcd_t;

   // Pad controls; an oe_n low means the pad is driven
   typedef struct packed {
      logic [1:0] p1_out;
      logic [1:0] p1_oe_n;
      logic [1:0] p1_pu_en;
      logic p1_pu_weak;
      logic [1:0] p2_out;
      logic [1:0] p2_oe_n;
      logic [1:0] p2_pu_en;
      logic [7:0] p3_out;
      logic [7:0] p3_oe_n;
   } gpt_pins_t;

   // All state of the block
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_have;
      logic w_have;
      logic [11:0] waddr;
      logic [7:0] wdata;
      logic wlane;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [1:0] p1_latch;
      logic [1:0] port1_direction;
      logic [1:0] p1_fsel;
      logic [3:0] port1_pad_config;
      logic [1:0] p2_latch;
      logic [1:0] port2_direction;
      logic [3:0] port2_pad_config;
      logic [7:0] p3_latch;
      logic [1:0] port3_direction;
      logic [1:0] p3_fsel;
      gpt_pins_t pins;
   } gpt_state_t;

   localparam gpt_pins_t GPT_PINS_RST = '{p1_oe_n: 2'h3, p2_oe_n: 2'h3, default: '0};
   localparam gpt_state_t GPT_STATE_RST = '{awready: 1'h1, wready: 1'h1, arready: 1'h1,
      pins: GPT_PINS_RST, default: '0};

endpackage

// ### verilog/gpt_ports.sv
// Three small GPIO ports with carrier and LCD segment sharing, behind an AXI4-Lite slave
// Operation
// R1: Port-one config bit 0 enables both pull-ups
// R2: Port-one config bit 1 selects open drain
// R3: Port-one config bit 2 selects weak pull-up
// R4: Port-one output pin never has pull-up
// R5: Without key strobe, pull-up stays continuous
// R6: Key strobe: pull-up in last 30 us
// R7: Port-one select bit 0 routes first carrier
// R8: Port-one select bit 1 routes second carrier
// R9: Port-two output pin drives its latch bit
// R10: Port-two output bit reads back one
// R11: Port-two input bit reads pad level
// R12: Port-two direction bit: 0 in, 1 out
// R13: Port-two config: pull-ups and open drain
// R14: Port three: eight segment pins, nibble direction
// R15: Port-three output drives CMOS, reads zero
// R16: Port-three input floats, reads pad level
// R17: Port-three direction bits set each nibble
// R18: Select bit 0 low: pins carry segments
// R19: Select bit 1 low: pins carry segments
// R20: Port-one output drives latch, reads one
// R21: Port-one direction bit: 0 in, 1 out
// R22: Carrier drives pin only when output
// R23: Segment nibble ignores its direction bit
`timescale 1ns/1ps
module gpt_ports
   import gpt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire gpt_pads_in_t pads_in,
   input wire gpt_lcd_t lcd,
   input wire logic first_timer_carrier,
   input wire logic second_timer_carrier,
   output gpt_pins_t pins
);

   gpt_state_t s_q; // Registered state
   gpt_state_t s_d; // Next state
   gpt_pins_t pins_w; // Pad controls computed from current state
   logic ks_window; // Last part of the active backplane line
   logic ks_active; // Key strobe in force
   logic [1:0] carrier; // Timer carriers per port-one pin

   // Bus outputs come straight from state flops
   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid = s_q.rvalid;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;
   assign pins = s_q.pins;

   // Remaining-cycle count from the LCD side locates the window end
   assign ks_window = lcd.backplane_low && (lcd.remain < GPT_KS_CYCLES); // [R6]
   // Strobing needs the LCD scan running, else pull-up stays steady
   assign ks_active = s_q.port1_pad_config[GPT_P1CFG_KS] && lcd.enable; // [R5] [R6]
   assign carrier = {second_timer_carrier, first_timer_carrier};
   // Strength is shared by both pins
   assign pins_w.p1_pu_weak = s_q.port1_pad_config[GPT_P1CFG_WEAK]; // [R3]

   // Per-pin logic of ports one and two
   for (genvar i = 0; i < 2; i++) begin : g_p12
      logic p1_val; // Value presented by port-one pin
      // Carrier replaces the latch only through an output driver
      assign p1_val = s_q.p1_fsel[i] ? carrier[i] : s_q.p1_latch[i]; // [R7] [R8] [R22]
      assign pins_w.p1_out[i] = p1_val; // [R20]
      // Open drain only pulls low; a one releases the pad
      assign pins_w.p1_oe_n[i] = !(s_q.port1_direction[i] &&
         !(s_q.port1_pad_config[GPT_P1CFG_NMOS] && p1_val)); // [R2] [R21]
      // Output pins lose the pull-up whatever the enable says
      assign pins_w.p1_pu_en[i] = s_q.port1_pad_config[GPT_P1CFG_PU] && !s_q.port1_direction[i] &&
         (!ks_active || ks_window); // [R1] [R4] [R5] [R6]
      assign pins_w.p2_out[i] = s_q.p2_latch[i]; // [R9]
      assign pins_w.p2_oe_n[i] = !(s_q.port2_direction[i] &&
         !(s_q.port2_pad_config[GPT_P2CFG_NMOS + i] && s_q.p2_latch[i])); // [R12] [R13]
      // Pull-up on an output pin is pointless current, so gate it off
      assign pins_w.p2_pu_en[i] = s_q.port2_pad_config[GPT_P2CFG_PU + i] && !s_q.port2_direction[i]; // [R13]
   end

   // Per-pin logic of port three; pin k carries column line 7-k
   for (genvar i = 0; i < 8; i++) begin : g_p3
      logic seg_mode; // Nibble handed to the LCD
      assign seg_mode = !s_q.p3_fsel[i / 4]; // [R18] [R19]
      // Segment use overrides the direction bit
      assign pins_w.p3_out[i] = seg_mode ? lcd.column_drive[7 - i] : s_q.p3_latch[i]; // [R23]
      // Always CMOS, no pull-up, float as input
      assign pins_w.p3_oe_n[i] = seg_mode ? 1'b0 : !s_q.port3_direction[i / 4]; // [R14] [R15] [R16] [R17]
   end

   // Next-state logic: bus slave, registers and pad controls
   always_comb begin
      s_d = s_q;
      s_d.pins = pins_w;
      // Response taken by the master
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end
      // Address and data may arrive in either order
      if (s_q.awready && awvalid) begin
         s_d.aw_have = 1'b1;
         s_d.waddr = awaddr;
      end
      if (s_q.wready && wvalid) begin
         s_d.w_have = 1'b1;
         s_d.wdata = wdata[7:0];
         s_d.wlane = wstrb[0];
      end
      // Both halves present and no response pending: commit
      if (s_d.aw_have && s_d.w_have && !s_d.bvalid) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = GPT_RESP_OKAY;
         // Registers live in byte lane 0; other lanes are dropped
         case (s_d.waddr)
            GPT_ADDR_P1_FSEL: begin
               if (s_d.wlane) s_d.p1_fsel = s_d.wdata[1:0]; // [R7] [R8]
            end
            GPT_ADDR_P3_FSEL: begin
               if (s_d.wlane) s_d.p3_fsel = s_d.wdata[1:0]; // [R18] [R19]
            end
            // Latch value shows only through a driving pin
            GPT_ADDR_P1_LATCH: begin
               if (s_d.wlane) s_d.p1_latch = s_d.wdata[1:0];
            end
            // Readback comes from direction and pad, not here
            GPT_ADDR_P2_LATCH: begin
               if (s_d.wlane) s_d.p2_latch = s_d.wdata[1:0];
            end
            GPT_ADDR_P3_LATCH: begin
               if (s_d.wlane) s_d.p3_latch = s_d.wdata;
            end
            GPT_ADDR_PORT1_DIRECTION: begin
               if (s_d.wlane) s_d.port1_direction = s_d.wdata[1:0]; // [R21]
            end
            // Pull-up, driver type, strength, key strobe
            GPT_ADDR_PORT1_PAD_CONFIG: begin
               if (s_d.wlane) s_d.port1_pad_config = s_d.wdata[3:0];
            end
            GPT_ADDR_PORT2_DIRECTION: begin
               if (s_d.wlane) s_d.port2_direction = s_d.wdata[1:0]; // [R12]
            end
            // Pull-ups low bits, driver types high bits
            GPT_ADDR_PORT2_PAD_CONFIG: begin
               if (s_d.wlane) s_d.port2_pad_config = s_d.wdata[3:0]; // [R13]
            end
            // One bit per nibble, not per pin
            GPT_ADDR_PORT3_DIRECTION: begin
               if (s_d.wlane) s_d.port3_direction = s_d.wdata[1:0]; // [R17]
            end
            // Unmapped address: error, nothing stored
            default: begin
               s_d.bresp = GPT_RESP_SLVERR;
            end
         endcase
      end
      // Hold off new halves while one is parked or a response waits
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready = !s_d.w_have && !s_d.bvalid;
      // Read data taken by the master
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      // Read: answer one cycle after the address is taken
      if (s_q.arready && arvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = GPT_RESP_OKAY;
         s_d.rdata = 32'h0000_0000;
         case (araddr)
            // Settings read back as written
            GPT_ADDR_P1_FSEL: s_d.rdata[1:0] = s_q.p1_fsel;
            GPT_ADDR_P3_FSEL: s_d.rdata[1:0] = s_q.p3_fsel;
            // Output bits read as one, input bits read the pad
            GPT_ADDR_P1_LATCH: s_d.rdata[1:0] = s_q.port1_direction | pads_in.p1_in; // [R20]
            GPT_ADDR_P2_LATCH: s_d.rdata[1:0] = s_q.port2_direction | pads_in.p2_in; // [R10] [R11]
            // Output nibbles read as zero; segment nibbles still show the pad
            GPT_ADDR_P3_LATCH: begin
               s_d.rdata[7:0] = pads_in.p3_in &
                  ~({{4{s_q.port3_direction[1] & s_q.p3_fsel[1]}},
                     {4{s_q.port3_direction[0] & s_q.p3_fsel[0]}}}); // [R15] [R16]
            end
            // Reserved bits stay zero
            GPT_ADDR_PORT1_DIRECTION: s_d.rdata[1:0] = s_q.port1_direction;
            GPT_ADDR_PORT1_PAD_CONFIG: s_d.rdata[3:0] = s_q.port1_pad_config;
            GPT_ADDR_PORT2_DIRECTION: s_d.rdata[1:0] = s_q.port2_direction;
            GPT_ADDR_PORT2_PAD_CONFIG: s_d.rdata[3:0] = s_q.port2_pad_config;
            GPT_ADDR_PORT3_DIRECTION: s_d.rdata[1:0] = s_q.port3_direction;
            // Unmapped: zero data with error
            default: s_d.rresp = GPT_RESP_SLVERR;
         endcase
      end
      // One read outstanding at a time
      s_d.arready = !s_d.rvalid;
   end

   // State register; clock enable freezes everything, but the synchronous reset still loads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= GPT_STATE_RST;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // Checks share the bus clock and reset
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Output pin never keeps its pull-up
   property p_r4_pu_off;
      ce && s_q.port1_direction[0] |=> !pins.p1_pu_en[0];
   endproperty
   a_r4_pu_off: assert property (p_r4_pu_off) else $error("pull-up on output pin"); // [R4]

   // Steady pull-up without key strobe
   property p_r5_pu_steady;
      ce && s_q.port1_pad_config[GPT_P1CFG_PU] && !s_q.port1_pad_config[GPT_P1CFG_KS] && !s_q.port1_direction[1]
         |=> pins.p1_pu_en[1] [*1];
   endproperty
   a_r5_pu_steady: assert property (p_r5_pu_steady) else $error("pull-up missing"); // [R5]

   // Strobed pull-up only in the window
   property p_r6_window;
      ce && s_q.port1_pad_config[GPT_P1CFG_PU] && s_q.port1_pad_config[GPT_P1CFG_KS] && lcd.enable &&
         !s_q.port1_direction[0] |=> pins.p1_pu_en[0] == $past(ks_window);
   endproperty
   a_r6_window: assert property (p_r6_window) else $error("strobe window wrong"); // [R6]

   // Carrier on an output pin
   property p_r7_carrier;
      ce && s_q.p1_fsel[0] && s_q.port1_direction[0] |=> pins.p1_out[0] == $past(first_timer_carrier);
   endproperty
   a_r7_carrier: assert property (p_r7_carrier) else $error("carrier not routed"); // [R7]

   // Port-two output drives the latch through CMOS
   property p_r9_drive;
      ce && s_q.port2_direction[0] && !s_q.port2_pad_config[GPT_P2CFG_NMOS]
         |=> !pins.p2_oe_n[0] && pins.p2_out[0] == $past(s_q.p2_latch[0]);
   endproperty
   a_r9_drive: assert property (p_r9_drive) else $error("port two not driven"); // [R9]

   // Read of output bits gives ones
   property p_r10_readback;
      ce && arvalid && s_q.arready && araddr == GPT_ADDR_P2_LATCH && s_q.port2_direction == 2'h3
         |=> rvalid && rdata == 32'h0000_0003;
   endproperty
   a_r10_readback: assert property (p_r10_readback) else $error("readback not one"); // [R10]

   // Read of input bits gives the pad
   property p_r11_pad;
      ce && arvalid && s_q.arready && araddr == GPT_ADDR_P2_LATCH && s_q.port2_direction == 2'h0
         |=> rdata[1:0] == $past(pads_in.p2_in);
   endproperty
   a_r11_pad: assert property (p_r11_pad) else $error("pad level not read"); // [R11]

   // Direction write lands in the register and gets its response
   property p_r12_dir_write;
      ce && awvalid && s_q.awready && wvalid && s_q.wready && !s_q.bvalid &&
         awaddr == GPT_ADDR_PORT2_DIRECTION && wstrb[0]
         |=> bvalid && s_q.port2_direction == $past(wdata[1:0]);
   endproperty
   a_r12_dir_write: assert property (p_r12_dir_write) else $error("direction lost"); // [R12]

   // Port-three output nibble reads zero
   property p_r15_zero;
      ce && arvalid && s_q.arready && araddr == GPT_ADDR_P3_LATCH &&
         s_q.port3_direction == 2'h3 && s_q.p3_fsel == 2'h3 |=> rdata == 32'h0000_0000;
   endproperty
   a_r15_zero: assert property (p_r15_zero) else $error("port three read not zero"); // [R15]

   // Segment nibble carries reversed column lines
   property p_r18_seg;
      // Skip the last reset edge: pins still hold reset values one cycle on
      ce && aresetn && !s_q.p3_fsel[0] |=> !pins.p3_oe_n[0] &&
         pins.p3_out[0] == $past(lcd.column_drive[7])
         && pins.p3_out[3] == $past(lcd.column_drive[4]);
   endproperty
   a_r18_seg: assert property (p_r18_seg) else $error("segment not routed"); // [R18]

   // Response holds until taken
   property p_b_hold;
      bvalid && !bready |=> bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");

   // Pull-up off while its enable is clear
   property p_r1_pu_off;
      ce && !s_q.port1_pad_config[GPT_P1CFG_PU] |=> pins.p1_pu_en == 2'h0;
   endproperty
   a_r1_pu_off: assert property (p_r1_pu_off) else $error("pull-up without enable"); // [R1]

   // Open drain releases a high carrier
   property p_r2_release;
      ce && s_q.port1_pad_config[GPT_P1CFG_NMOS] && s_q.port1_direction[0] && s_q.p1_fsel[0] &&
         first_timer_carrier |=> pins.p1_oe_n[0];
   endproperty
   a_r2_release: assert property (p_r2_release) else $error("open drain drove high"); // [R2]

   // Strength bit reaches the pad a cycle later
   property p_r3_strength;
      ce |=> pins.p1_pu_weak == $past(s_q.port1_pad_config[GPT_P1CFG_WEAK]);
   endproperty
   a_r3_strength: assert property (p_r3_strength) else $error("pull-up strength wrong"); // [R3]

   // Second carrier on an output pin
   property p_r8_carrier;
      ce && s_q.p1_fsel[1] && s_q.port1_direction[1] |=> pins.p1_out[1] == $past(second_timer_carrier);
   endproperty
   a_r8_carrier: assert property (p_r8_carrier) else $error("second carrier lost"); // [R8]

   // Port-two input keeps its pull-up
   property p_r13_pull;
      ce && s_q.port2_pad_config[GPT_P2CFG_PU + 1] && !s_q.port2_direction[1] |=> pins.p2_pu_en[1];
   endproperty
   a_r13_pull: assert property (p_r13_pull) else $error("port two pull-up missing"); // [R13]

   // Port-three input nibble floats
   property p_r16_float;
      ce && s_q.p3_fsel[0] && !s_q.port3_direction[0] |=> pins.p3_oe_n[3:0] == 4'hf;
   endproperty
   a_r16_float: assert property (p_r16_float) else $error("input nibble driven"); // [R16]

   // Port-three output nibble drives its latch
   property p_r17_nibble;
      ce && s_q.p3_fsel[1] && s_q.port3_direction[1] |=> pins.p3_oe_n[7:4] == 4'h0 &&
         pins.p3_out[7:4] == $past(s_q.p3_latch[7:4]);
   endproperty
   a_r17_nibble: assert property (p_r17_nibble) else $error("nibble not driven"); // [R17]

   // Upper segment nibble, reversed too
   property p_r19_seg;
      ce && aresetn && !s_q.p3_fsel[1] |=> !pins.p3_oe_n[4] &&
         pins.p3_out[4] == $past(lcd.column_drive[3]) &&
         pins.p3_out[7] == $past(lcd.column_drive[0]);
   endproperty
   a_r19_seg: assert property (p_r19_seg) else $error("upper segments lost"); // [R19]

   // Input pin is never driven
   property p_r21_input;
      ce && !s_q.port1_direction[1] |=> pins.p1_oe_n[1];
   endproperty
   a_r21_input: assert property (p_r21_input) else $error("input pin driven"); // [R21]

   // Port-one output bits read as ones
   property p_r20_readback;
      ce && arvalid && s_q.arready && araddr == GPT_ADDR_P1_LATCH && s_q.port1_direction == 2'h3
         |=> rdata == 32'h0000_0003;
   endproperty
   a_r20_readback: assert property (p_r20_readback) else $error("readback not ones"); // [R20]

   // Main scenarios
   c_write: cover property (bvalid && bready && bresp == GPT_RESP_OKAY);
   c_read: cover property (rvalid && rready && rresp == GPT_RESP_OKAY);
   c_strobe: cover property (ks_active && ks_window && pins.p1_pu_en[0]);
   c_unmapped: cover property (rvalid && rresp == GPT_RESP_SLVERR);
   c_carrier: cover property (s_q.p1_fsel[0] && s_q.port1_direction[0] && !pins.p1_oe_n[0]);

endmodule // gpt_ports

// ### test/gpt_pad_model.sv
// Pad-side model: resolves each pin level from block drivers, pull-ups and board drive
`timescale 1ns/1ps
module gpt_pad_model
   import gpt_pkg::*;
(
   input wire logic aclk,
   input wire gpt_pins_t pins,
   input wire gpt_pads_in_t ext_lvl,
   input wire gpt_pads_in_t ext_en,
   output gpt_pads_in_t pads_in
);
   logic [11:0] float_q = 12'h5a5; // Undriven lines wander, never hold old value
   logic [11:0] drv_n; // Low where the block drives
   logic [11:0] val; // Block output levels
   logic [11:0] pu; // Pull-up requests

   // Float pattern flips each cycle so a stale read cannot pass
   always @(posedge aclk) begin
      float_q <= ~float_q;
   end

   assign drv_n = {pins.p1_oe_n, pins.p2_oe_n, pins.p3_oe_n};
   assign val = {pins.p1_out, pins.p2_out, pins.p3_out};
   assign pu = {pins.p1_pu_en, pins.p2_pu_en, 8'h00}; // Port three floats

   // Driver wins, then board, then pull-up
   always_comb begin
      for (int i = 0; i < 12; i++) begin
         pads_in[i] = !drv_n[i] ? val[i] : ext_en[i] ? ext_lvl[i] : pu[i] ? 1'b1 : float_q[i];
      end
   end
endmodule // gpt_pad_model

// ### test/tb_top.sv
// Bench: register-level tests of the three-port block over the register bus
`timescale 1ns/1ps
module tb_top
   import gpt_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic first_car = 1'b0;
   logic second_car = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h1; // Only lane 0 carries data
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   gpt_pads_in_t pads_in;
   gpt_pads_in_t ext_lvl = '0; // Board drive levels
   gpt_pads_in_t ext_en = '0; // Board drive enables
   gpt_lcd_t lcd = '{column_drive: 8'hc5, default: '0};
   gpt_pins_t pins;
   logic [7:0] p1_v; // Port one: out, oe_n, pull-up, weak
   logic [7:0] p2_v; // Port two: out, oe_n, pull-up
   logic [11:0] rst_regs [6] = '{GPT_ADDR_P1_FSEL, GPT_ADDR_P3_FSEL, GPT_ADDR_PORT1_DIRECTION,
      GPT_ADDR_PORT1_PAD_CONFIG, GPT_ADDR_PORT2_DIRECTION, GPT_ADDR_PORT2_PAD_CONFIG};
   int err_total = 0;
   int checks = 0;

   assign p1_v = {1'b0, pins.p1_out, pins.p1_oe_n, pins.p1_pu_en, pins.p1_pu_weak};
   assign p2_v = {2'h0, pins.p2_out, pins.p2_oe_n, pins.p2_pu_en};

   // 50 ns clock
   always #25 aclk = ~aclk;

   gpt_ports gpt_ports_i (
      .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(1'b1), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
      .rvalid(rvalid), .rready(1'b1), .rdata(rdata), .rresp(rresp),
      .pads_in(pads_in), .lcd(lcd), .first_timer_carrier(first_car),
      .second_timer_carrier(second_car), .pins(pins)
   );

   gpt_pad_model gpt_pad_model_i (
      .aclk(aclk), .pins(pins), .ext_lvl(ext_lvl), .ext_en(ext_en), .pads_in(pads_in)
   );

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // A wait that ran out ends the run as a failure
   task automatic hung(input int n);
      if (n >= 100) begin
         err_total++;
         tally_and_finish();
      end
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 100);
      hung(n);
      chk8({6'h00, bresp}, {6'h00, er});
   endtask

   // Read: data and response taken at the edge rvalid is seen
   task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 100);
      hung(n);
      chk32(rdata, {24'h00_0000, ed});
      chk8({6'h00, rresp}, {6'h00, er});
   endtask

   // Pins lag one cycle; three edges leave margin
   task automatic settle();
      repeat (3) @(posedge aclk);
   endtask

   // Main sequence
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      // Reset state
      chk8(p1_v, 8'h18);
      chk8(p2_v, 8'h0c);
      chk8(pins.p3_out, 8'ha3);
      chk8(pins.p3_oe_n, 8'h00);
      foreach (rst_regs[i]) rd(rst_regs[i], 8'h00, GPT_RESP_OKAY);
      rd(12'h004, 8'h00, GPT_RESP_SLVERR);
      wr(12'h004, 8'hff, GPT_RESP_SLVERR);
      // Port two: input read, output read, lane-0 strobe off
      ext_en.p2_in <= 2'h3;
      ext_lvl.p2_in <= 2'h2;
      rd(GPT_ADDR_P2_LATCH, 8'h02, GPT_RESP_OKAY);
      wr(GPT_ADDR_P2_LATCH, 8'h01, GPT_RESP_OKAY);
      wr(GPT_ADDR_PORT2_DIRECTION, 8'h03, GPT_RESP_OKAY);
      rd(GPT_ADDR_P2_LATCH, 8'h03, GPT_RESP_OKAY);
      wstrb <= 4'h0;
      wr(GPT_ADDR_P2_LATCH, 8'h02, GPT_RESP_OKAY);
      wstrb <= 4'h1;
      settle();
      chk8(p2_v, 8'h10);
      wr(GPT_ADDR_PORT2_PAD_CONFIG, 8'h04, GPT_RESP_OKAY);
      settle();
      chk8(p2_v, 8'h14);
      wr(GPT_ADDR_PORT2_DIRECTION, 8'h00, GPT_RESP_OKAY);
      wr(GPT_ADDR_PORT2_PAD_CONFIG, 8'h03, GPT_RESP_OKAY);
      settle();
      chk8(p2_v & 8'h0f, 8'h0f);
      // Port one: pull-up, direction, driver type, carriers
      wr(GPT_ADDR_PORT1_PAD_CONFIG, 8'h01, GPT_RESP_OKAY);
      settle();
      chk8(p1_v, 8'h1e);
      wr(GPT_ADDR_PORT1_DIRECTION, 8'h01, GPT_RESP_OKAY);
      settle();
      chk8(p1_v, 8'h14);
      wr(GPT_ADDR_PORT1_PAD_CONFIG, 8'h05, GPT_RESP_OKAY);
      settle();
      chk8(p1_v, 8'h15);
      wr(GPT_ADDR_P1_LATCH, 8'h02, GPT_RESP_OKAY);
      wr(GPT_ADDR_PORT1_DIRECTION, 8'h03, GPT_RESP_OKAY);
      rd(GPT_ADDR_P1_LATCH, 8'h03, GPT_RESP_OKAY);
      settle();
      chk8(p1_v, 8'h41);
      first_car <= 1'b1;
      wr(GPT_ADDR_P1_FSEL, 8'h03, GPT_RESP_OKAY);
      settle();
      chk8(p1_v, 8'h21);
      wr(GPT_ADDR_PORT1_PAD_CONFIG, 8'h06, GPT_RESP_OKAY);
      settle();
      chk8(p1_v, 8'h29);
      wr(GPT_ADDR_PORT1_DIRECTION, 8'h00, GPT_RESP_OKAY);
      settle();
      chk8(p1_v & 8'h1f, 8'h19);
      // Key strobe window at its boundary
      wr(GPT_ADDR_PORT1_PAD_CONFIG, 8'h09, GPT_RESP_OKAY);
      lcd.enable <= 1'b1;
      lcd.backplane_low <= 1'b1;
      lcd.remain <= 16'h0258;
      settle();
      chk8(p1_v & 8'h07, 8'h00);
      lcd.remain <= 16'h0257;
      settle();
      chk8(p1_v & 8'h07, 8'h06);
      lcd.backplane_low <= 1'b0;
      settle();
      chk8(p1_v & 8'h07, 8'h00);
      lcd.enable <= 1'b0;
      settle();
      chk8(p1_v & 8'h07, 8'h06);
      // Port three: segments, nibble direction, reads
      wr(GPT_ADDR_PORT3_DIRECTION, 8'h03, GPT_RESP_OKAY);
      settle();
      chk8(pins.p3_out, 8'ha3);
      wr(GPT_ADDR_P3_LATCH, 8'h56, GPT_RESP_OKAY);
      wr(GPT_ADDR_P3_FSEL, 8'h01, GPT_RESP_OKAY);
      settle();
      chk8(pins.p3_out, 8'ha6);
      rd(GPT_ADDR_P3_LATCH, 8'ha0, GPT_RESP_OKAY);
      ext_en.p3_in <= 8'h0f;
      ext_lvl.p3_in <= 8'h09;
      wr(GPT_ADDR_PORT3_DIRECTION, 8'h02, GPT_RESP_OKAY);
      settle();
      chk8(pins.p3_oe_n, 8'h0f);
      rd(GPT_ADDR_P3_LATCH, 8'ha9, GPT_RESP_OKAY);
      wr(GPT_ADDR_P3_FSEL, 8'h03, GPT_RESP_OKAY);
      settle();
      chk8(pins.p3_oe_n, 8'h0f);
      chk8(pins.p3_out & 8'hf0, 8'h50);
      rd(GPT_ADDR_P3_LATCH, 8'h09, GPT_RESP_OKAY);
      tally_and_finish();
   end
endmodule // tb_top
